// *** cond_pkg.sv ***
// Package with widths, condition codes and carrier structs for conditional inputs
package cond_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int PORT_W = 8;
  localparam int WORD_W = 32;
  localparam int PCNT_W = 16;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [PORT_W-1:0] PINS_RST = 8'h00;

  // ----------------------------------------
  // Condition codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    COND_NONE,
    COND_EQ,
    COND_NEQ,
    COND_EQ_AT,
    COND_NEQ_AT
  } cond_t;

  // Port input request from the thread
  typedef struct packed {
    logic valid;
    cond_t cond;
    logic [WORD_W-1:0] val;
    logic [PCNT_W-1:0] time_val;
  } port_req_t;

  // Timer input request from the thread
  typedef struct packed {
    logic valid;
    logic after_en;
    logic [WORD_W-1:0] val;
  } tmr_req_t;
endpackage : cond_pkg

// *** after_cmp.sv ***
// Wrapping compare: is count a later than count b
`timescale 1ns/10ps
`default_nettype none
module after_cmp
  import cond_pkg::*;
(
  input wire logic [cond_pkg::WORD_W-1:0] i_a,
  input wire logic [cond_pkg::WORD_W-1:0] i_b,
  output logic o_after
);
  logic [WORD_W-1:0] diff;

  // ----------------------------------------
  // Signed difference test
  // ----------------------------------------
  // RULE7: signed difference positive
  always_comb begin
    diff = i_a - i_b;
    o_after = ($signed(diff) > $signed(WORD_RST));
  end
endmodule : after_cmp
`default_nettype wire

// *** port_timer_input_conditions.sv ***
// Conditional port and timer input logic
// Operation
// RULE1: Equality: port input pending until pins equal truncated compare value.
// RULE2: Inequality: port input pending until pins differ from truncated compare value.
// RULE3: Timed equality: ready when pins match and port counter equals time.
// RULE4: Timed inequality: ready when pins differ and port counter equals time.
// RULE5: Thread uses timed conditions only on unbuffered ports.
// RULE6: Timer after-condition: pending until timer later than compare value.
// RULE7: A later than B when signed wrapping difference A minus B exceeds zero.
`timescale 1ns/10ps
`default_nettype none
module port_timer_input_conditions
  import cond_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic [cond_pkg::PORT_W-1:0] i_pins,
  input wire cond_pkg::port_req_t i_port_req,
  input wire cond_pkg::tmr_req_t i_tmr_req,
  output logic o_port_busy,
  output logic o_port_ready,
  output logic [cond_pkg::PORT_W-1:0] o_port_data,
  output logic [cond_pkg::PCNT_W-1:0] o_port_count,
  output logic o_tmr_busy,
  output logic o_tmr_ready,
  output logic [cond_pkg::WORD_W-1:0] o_tmr_data
);
  import cond_pkg::*;

  typedef enum logic [1:0] {IDLE, WAIT} pst_t;

  // Pins compare against low port-width bits of the value
  function automatic logic pins_hit(input cond_t c, input logic [PORT_W-1:0] p,
                                    input logic [WORD_W-1:0] v);
    logic eq;
    eq = (p == v[PORT_W-1:0]);
    pins_hit = (c == COND_EQ || c == COND_EQ_AT) ? eq : !eq;
  endfunction : pins_hit

  // Port side state
  pst_t pst_q, pst_d;
  logic pbusy_q, pbusy_d;
  cond_t cond_q, cond_d;
  logic [WORD_W-1:0] pval_q, pval_d;
  logic [PCNT_W-1:0] ptime_q, ptime_d;
  logic [PCNT_W-1:0] pcnt_q, pcnt_d;
  logic prdy_q, prdy_d;
  logic [PORT_W-1:0] pdat_q, pdat_d;
  // Timer side state
  logic tbusy_q, tbusy_d;
  logic [WORD_W-1:0] tval_q, tval_d;
  logic [WORD_W-1:0] tcnt_q, tcnt_d;
  logic trdy_q, trdy_d;
  logic [WORD_W-1:0] tdat_q, tdat_d;
  logic tmr_after;
  logic hit;

  // ----------------------------------------
  // Timer compare
  // ----------------------------------------
  after_cmp u_after (
    .i_a(tcnt_q),
    .i_b(tval_q),
    .o_after(tmr_after)
  );

  // ----------------------------------------
  // Port side next state
  // ----------------------------------------
  // Take a request when idle, then test the pins on every enabled cycle
  always_comb begin
    pst_d = pst_q;
    cond_d = cond_q;
    pval_d = pval_q;
    ptime_d = ptime_q;
    prdy_d = 1'b0;
    pdat_d = pdat_q;
    hit = 1'b0;
    unique case (pst_q)
      IDLE: begin
        if (i_port_req.valid && i_port_req.cond != COND_NONE) begin
          pst_d = WAIT;
          cond_d = i_port_req.cond;
          pval_d = i_port_req.val;
          ptime_d = i_port_req.time_val;
        end else if (i_port_req.valid) begin
          // Unconditional input completes at once
          prdy_d = 1'b1;
          pdat_d = i_pins;
        end
      end
      WAIT: begin
        // RULE1: equality match
        // RULE2: inequality match
        hit = pins_hit(cond_q, i_pins, pval_q);
        // RULE3: timed equality gate
        // RULE4: timed inequality gate
        // RULE5: no buffering here, so timed forms always apply
        if (cond_q == COND_EQ_AT || cond_q == COND_NEQ_AT) begin
          hit = hit && (pcnt_q == ptime_q);
        end
        if (hit) begin
          pst_d = IDLE;
          prdy_d = 1'b1;
          pdat_d = i_pins;
        end
      end
    endcase
    // Busy is registered so the output comes straight from a flop
    pbusy_d = (pst_d == WAIT);
  end

  // Port registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pst_q <= IDLE;
      pbusy_q <= 1'b0;
      cond_q <= COND_NONE;
      pval_q <= WORD_RST;
      ptime_q <= '0;
      prdy_q <= 1'b0;
      pdat_q <= PINS_RST;
    end else if (i_ce) begin
      pst_q <= pst_d;
      pbusy_q <= pbusy_d;
      cond_q <= cond_d;
      pval_q <= pval_d;
      ptime_q <= ptime_d;
      prdy_q <= prdy_d;
      pdat_q <= pdat_d;
    end
  end

  // ----------------------------------------
  // Port counter
  // ----------------------------------------
  // Free-running, so a timed input can aim at any slot in the next wrap
  always_comb begin
    pcnt_d = pcnt_q + 16'h0001;
  end

  // Counter register, frozen with the rest while the enable is low
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pcnt_q <= '0;
    end else if (i_ce) begin
      pcnt_q <= pcnt_d;
    end
  end

  // ----------------------------------------
  // Timer side next state
  // ----------------------------------------
  always_comb begin
    tbusy_d = tbusy_q;
    tval_d = tval_q;
    trdy_d = 1'b0;
    tdat_d = tdat_q;
    if (!tbusy_q && i_tmr_req.valid) begin
      if (i_tmr_req.after_en) begin
        tbusy_d = 1'b1;
        tval_d = i_tmr_req.val;
      end else begin
        trdy_d = 1'b1;
        tdat_d = tcnt_q;
      end
    end else if (tbusy_q) begin
      // RULE6: release once timer is after value
      if (tmr_after) begin
        tbusy_d = 1'b0;
        trdy_d = 1'b1;
        tdat_d = tcnt_q;
      end
    end
  end

  // Timer registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tbusy_q <= 1'b0;
      tval_q <= WORD_RST;
      trdy_q <= 1'b0;
      tdat_q <= WORD_RST;
    end else if (i_ce) begin
      tbusy_q <= tbusy_d;
      tval_q <= tval_d;
      trdy_q <= trdy_d;
      tdat_q <= tdat_d;
    end
  end

  // ----------------------------------------
  // Timer counter
  // ----------------------------------------
  // Wraps silently; the signed compare keeps ordering across the wrap
  always_comb begin
    tcnt_d = tcnt_q + 32'h0000_0001;
  end

  // Timer count register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tcnt_q <= WORD_RST;
    end else if (i_ce) begin
      tcnt_q <= tcnt_d;
    end
  end

  // ----------------------------------------
  // Outputs, all from flops
  // ----------------------------------------
  assign o_port_busy = pbusy_q;
  assign o_port_ready = prdy_q;
  assign o_port_data = pdat_q;
  assign o_port_count = pcnt_q;
  assign o_tmr_busy = tbusy_q;
  assign o_tmr_ready = trdy_q;
  assign o_tmr_data = tdat_q;
endmodule : port_timer_input_conditions
`default_nettype wire

// *** cond_props.sv ***
// Checker for conditional port and timer inputs
`timescale 1ns/10ps
`default_nettype none
module cond_props
  import cond_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic [7:0] i_pins,
  input wire cond_pkg::port_req_t i_port_req,
  input wire cond_pkg::tmr_req_t i_tmr_req,
  input wire logic o_port_busy,
  input wire logic o_port_ready,
  input wire logic [7:0] o_port_data,
  input wire logic [15:0] o_port_count,
  input wire logic o_tmr_busy,
  input wire logic o_tmr_ready,
  input wire logic [31:0] o_tmr_data
);
  cond_t c_q;
  logic [31:0] v_q, t_q;
  logic [15:0] w_q;
  logic a_q;
  // Keep the request that was taken
  always_ff @(posedge i_clk) begin
    if (!i_srst && i_ce && i_port_req.valid && !o_port_busy) begin
      c_q <= i_port_req.cond;
      v_q <= i_port_req.val;
      w_q <= i_port_req.time_val;
    end
    if (!i_srst && i_ce && i_tmr_req.valid && !o_tmr_busy) begin
      t_q <= i_tmr_req.val;
      a_q <= i_tmr_req.after_en;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_eq_data: assert property (
    o_port_ready && c_q == COND_EQ |-> o_port_data == v_q[7:0]) else $error("eq data");
  a_eq_fire: assert property (
    o_port_busy && i_ce && c_q == COND_EQ && i_pins == v_q[7:0] |=> o_port_ready)
    else $error("eq missed");
  a_neq_data: assert property (
    o_port_ready && c_q == COND_NEQ |-> o_port_data != v_q[7:0]) else $error("neq data");
  a_neq_fire: assert property (
    o_port_busy && i_ce && c_q == COND_NEQ && i_pins != v_q[7:0] |=> o_port_ready)
    else $error("neq missed");
  a_eq_at: assert property (
    o_port_ready && c_q == COND_EQ_AT |-> o_port_data == v_q[7:0]
    && $past(o_port_count) == w_q) else $error("eq at");
  a_neq_at: assert property (
    o_port_ready && c_q == COND_NEQ_AT |-> o_port_data != v_q[7:0]
    && $past(o_port_count) == w_q) else $error("neq at");
  a_tmr_later: assert property (
    o_tmr_ready && a_q |-> $signed(o_tmr_data - t_q) > 0) else $error("timer early");
  a_rst_idle: assert property (disable iff (1'b0)
    i_srst |=> !o_port_busy && !o_tmr_busy && !o_port_ready) else $error("reset");
  c_eq: cover property (o_port_ready && c_q == COND_EQ);
  c_at: cover property (o_port_ready && c_q == COND_NEQ_AT);
  c_tmr: cover property (o_tmr_ready && a_q);
endmodule : cond_props
bind port_timer_input_conditions cond_props u_cond_props (
  .i_clk(i_clk),
  .i_srst(i_srst),
  .i_ce(i_ce),
  .i_pins(i_pins),
  .i_port_req(i_port_req),
  .i_tmr_req(i_tmr_req),
  .o_port_busy(o_port_busy),
  .o_port_ready(o_port_ready),
  .o_port_data(o_port_data),
  .o_port_count(o_port_count),
  .o_tmr_busy(o_tmr_busy),
  .o_tmr_ready(o_tmr_ready),
  .o_tmr_data(o_tmr_data)
);
`default_nettype wire

// *** pin_drv.sv ***
// Model of the external pin drivers
`timescale 1ns/10ps
`default_nettype none
module pin_drv (
  input wire logic [7:0] i_val,
  output logic [7:0] o_pins
);
  // Pins settle shortly after the bench moves them
  assign #2 o_pins = i_val;
endmodule : pin_drv
`default_nettype wire

// *** port_timer_input_conditions_tb_top.sv ***
// Bench for conditional port and timer inputs
`timescale 1ns/10ps
`default_nettype none
module port_timer_input_conditions_tb_top;
  import cond_pkg::*;
  logic i_clk = 0, i_srst = 1, i_ce = 1;
  logic [7:0] pv = 0, pd;
  wire logic [7:0] pins;
  port_req_t pr = '0;
  tmr_req_t tr = '0;
  logic pb, prd, tb, trd;
  logic [15:0] pc, tv;
  logic [31:0] td, c;
  int fail_count = 0, total_checks = 0, cyc = 0;
  pin_drv u_pin_drv (.i_val(pv), .o_pins(pins));
  port_timer_input_conditions u_port_timer_input_conditions (.i_clk(i_clk), .i_srst(i_srst),
    .i_ce(i_ce), .i_pins(pins), .i_port_req(pr), .i_tmr_req(tr), .o_port_busy(pb),
    .o_port_ready(prd), .o_port_data(pd), .o_port_count(pc), .o_tmr_busy(tb),
    .o_tmr_ready(trd), .o_tmr_data(td));
  initial forever #5 i_clk = ~i_clk;
  // Hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Bounded wait on a ready pulse
  task automatic wait_rdy(input bit t);
    int n = 0;
    while ((t ? trd : prd) !== 1'b1 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    // A ready that never comes is a mismatch
    if (n >= 200) begin
      fail_count++;
      summarize();
    end
  endtask : wait_rdy
  task automatic preq(input cond_t k, input logic [31:0] v, input logic [15:0] t);
    pr = '{1'b1, k, v, t};
    @(negedge i_clk);
    pr.valid = 1'b0;
  endtask : preq
  task automatic treq(input logic a, input logic [31:0] v);
    tr = '{1'b1, a, v};
    @(negedge i_clk);
    tr.valid = 1'b0;
  endtask : treq
  task automatic t_value;
    preq(COND_EQ, 32'hABCD_125A, '0);
    repeat (4) @(negedge i_clk);
    chk(prd, 0);
    pv = 8'h5A;
    wait_rdy(0);
    chk(pd, 8'h5A);
    preq(COND_NEQ, 32'hFFFF_FF5A, '0);
    repeat (4) @(negedge i_clk);
    chk(pb, 1);
    pv = 8'h34;
    wait_rdy(0);
    chk(pd, 8'h34);
    // Unconditional input in the ready cycle completes at once
    pv = 8'h6B;
    preq(COND_NONE, 32'h0, '0);
    wait_rdy(0);
    chk(pd, 8'h6B);
    $display("t_value done");
  endtask : t_value
  task automatic t_timed;
    pv = 8'h5A;
    for (int i = 0; i < 2; i++) begin
      tv = pc + 16'h8;
      preq(i ? COND_NEQ_AT : COND_EQ_AT, i ? 32'h0 : 32'h5A, tv);
      wait_rdy(0);
      chk(pc, tv + 16'h1);
      @(negedge i_clk);
    end
    $display("t_timed done");
  endtask : t_timed
  task automatic t_timer;
    treq(1'b0, '0);
    wait_rdy(1);
    c = td;
    @(negedge i_clk);
    treq(1'b1, c + 32'd20);
    chk(tb, 1);
    wait_rdy(1);
    chk(td, c + 32'd21);
    // Far half of the circle counts as past, so this completes at once
    c = td;
    treq(1'b1, c + 32'h9000_0000);
    wait_rdy(1);
    chk(td, c + 32'd2);
    $display("t_timer done");
  endtask : t_timer
  task automatic t_reset;
    // Time slot passes with the pins wrong, so the input must stay pending
    tv = pc + 16'h3;
    preq(COND_EQ_AT, 32'h77, tv);
    repeat (6) @(negedge i_clk);
    chk(pb, 1);
    i_srst = 1;
    @(negedge i_clk);
    chk(pb, 0);
    i_srst = 0;
    i_ce = 0;
    repeat (3) @(negedge i_clk);
    chk(pc, 0);
    i_ce = 1;
    $display("t_reset done");
  endtask : t_reset
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    repeat (3) @(negedge i_clk);
    i_srst = 0;
    t_value();
    t_timed();
    t_timer();
    t_reset();
    summarize();
  end
endmodule : port_timer_input_conditions_tb_top
`default_nettype wire
